// [design/ofsc_defs.vh]
// constants for the output freeze serial control block
`ifndef OFSC_DEFS_VH
`define OFSC_DEFS_VH

// freeze enable register layout, in arrival order
`define OFSC_NBITS       12
`define OFSC_CNT_W       4
`define OFSC_LAST_BIT    4'hb
`define OFSC_BANK_A_LSB  0
`define OFSC_BANK_B_LSB  4
`define OFSC_BANK_C_LSB  8
`define OFSC_FB_BIT      11
`define OFSC_ENA_RESET   12'hfff

// divider half periods in CLK cycles (defaults only)
`define OFSC_DIV_W       8
`define OFSC_HALF_A      8'h02
`define OFSC_HALF_B      8'h03
`define OFSC_HALF_C      8'h01
`define OFSC_HALF_FB     8'h02

`endif

// [design/ofsc_freeze_ctrl.v]
// serial freeze register, free-running dividers and glitch-free gating
`timescale 1ns/1ns
`include "ofsc_defs.vh"

// Operation
// - Twelve-bit serially loaded register holds one enable per freezable output.
// - First bank-C output and coincidence output are never gated.
// - Enable bit zero stops its output and holds it low.
// - Enable bit one lets its output toggle normally again.
// - Freeze takes effect only once the output is naturally low.
// - Release takes effect only while the internal clock is low.
// - Data is sampled on the serial clock rising edge; controller meets it.
// - Arrival order maps bits to bank A, bank B, bank C 1-3, feedback.
module ofsc_freeze_ctrl #(
  parameter [`OFSC_DIV_W-1:0] HALF_A  = `OFSC_HALF_A,
  parameter [`OFSC_DIV_W-1:0] HALF_B  = `OFSC_HALF_B,
  parameter [`OFSC_DIV_W-1:0] HALF_C  = `OFSC_HALF_C,
  parameter [`OFSC_DIV_W-1:0] HALF_FB = `OFSC_HALF_FB
) (
  // clock and reset
  input  wire       CLK,
  input  wire       ARST_N,
  // serial freeze port
  input  wire       FRZ_CLK,
  input  wire       FRZ_DATA,
  // clock outputs
  output reg  [3:0] BANK_A_CLOCK_OUTS,
  output reg  [3:0] BANK_B_CLOCK_OUTS,
  output reg        BANK_C_FIRST_OUT,
  output reg  [2:0] BANK_C_FREEZABLE_OUTS,
  output reg        FEEDBACK_CLOCK_OUT,
  output reg        COINCIDENCE_PULSE_OUT
);

  // receiver states: idle waits for a low start bit on a serial clock
  // rise, shift counts the twelve enable bits that follow it
  localparam ST_IDLE  = 1'b0;
  localparam ST_SHIFT = 1'b1;

  // divider helpers, shared by all four banks
  // a half period of one gives a tick on every clock, so the count
  // stays at zero and the raw clock toggles each cycle
  function [`OFSC_DIV_W-1:0] div_next;
    input [`OFSC_DIV_W-1:0] cnt;
    input [`OFSC_DIV_W-1:0] half;
    begin
      if (cnt >= half - 8'h01)
        div_next = 8'h00;
      else
        div_next = cnt + 8'h01;
    end
  endfunction

  function div_tick;
    input [`OFSC_DIV_W-1:0] cnt;
    input [`OFSC_DIV_W-1:0] half;
    begin
      div_tick = (cnt >= half - 8'h01);
    end
  endfunction

  reg  [2:0]               clk_sync;
  reg  [1:0]               data_sync;
  reg                      state;
  reg  [`OFSC_CNT_W-1:0]   bit_cnt;
  reg  [`OFSC_NBITS-1:0]   shift_reg;
  reg  [`OFSC_NBITS-1:0]   freeze_ena;
  reg  [`OFSC_NBITS-1:0]   run;
  reg  [`OFSC_DIV_W-1:0]   cnt_a;
  reg  [`OFSC_DIV_W-1:0]   cnt_b;
  reg  [`OFSC_DIV_W-1:0]   cnt_c;
  reg  [`OFSC_DIV_W-1:0]   cnt_fb;
  reg                      raw_a;
  reg                      raw_b;
  reg                      raw_c;
  reg                      raw_fb;
  wire                     frz_rise;
  wire                     frz_bit;
  wire                     tick_a;
  wire                     tick_b;
  wire                     tick_c;
  wire                     tick_fb;
  wire [`OFSC_NBITS-1:0]   raw_vec;
  wire [`OFSC_NBITS-1:0]   next_run;
  wire [`OFSC_NBITS-1:0]   next_shift;

  // pin synchronisers; edge detect reads only stages two and three
  // both pins pass the same number of stages, so the data bit seen
  // with a detected rise is the one that stood at the pin's rise
  // data resets high, the idle level, so no false start follows reset
  // clock resets low; a pin high at release may look like one rise,
  // which is harmless while the data line idles high
  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      clk_sync  <= 3'h0;
      data_sync <= 2'h3;
    end else begin
      clk_sync  <= {clk_sync[1:0], FRZ_CLK};
      data_sync <= {data_sync[0], FRZ_DATA};
    end
  end

  assign frz_rise = clk_sync[1] & ~clk_sync[2];
  assign frz_bit  = data_sync[1];
  // first arriving bit lands in bit 0
  assign next_shift = shift_reg | ({{(`OFSC_NBITS-1){1'b0}}, frz_bit}
                      << bit_cnt);

  // serial receiver: start bit, twelve data bits, back to idle
  // bit_cnt numbers the data bits from zero; the rise that carries
  // the last one also copies the whole pattern into freeze_ena
  // a reset in mid-load drops the partial pattern, but a load cut short
  // without one is completed by the next bits and copied into freeze_ena
  // no abort exists: any low seen while idle opens a new load
  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state      <= ST_IDLE;
      bit_cnt    <= 4'h0;
      shift_reg  <= 12'h000;
      freeze_ena <= `OFSC_ENA_RESET;
    end else if (frz_rise) begin
      case (state)
        ST_IDLE: begin
          // a high line between loads is simply ignored
          if (!frz_bit) begin
            state     <= ST_SHIFT;
            bit_cnt   <= 4'h0;
            shift_reg <= 12'h000;
          end
        end
        ST_SHIFT: begin
          shift_reg <= next_shift;
          bit_cnt   <= bit_cnt + 4'h1;
          if (bit_cnt == `OFSC_LAST_BIT) begin
            freeze_ena <= next_shift;
            state      <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  assign tick_a  = div_tick(cnt_a, HALF_A);
  assign tick_b  = div_tick(cnt_b, HALF_B);
  assign tick_c  = div_tick(cnt_c, HALF_C);
  assign tick_fb = div_tick(cnt_fb, HALF_FB);

  // free-running dividers; never stopped by freezing, so phase holds
  // the raw clocks are shared by a whole bank; only the gate below
  // differs per output, so a released output is in phase at once
  // trade-off: one divider per bank, not per output, saves area but
  // ties all outputs of a bank to one rate
  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      cnt_a  <= 8'h00;
      cnt_b  <= 8'h00;
      cnt_c  <= 8'h00;
      cnt_fb <= 8'h00;
      raw_a  <= 1'b0;
      raw_b  <= 1'b0;
      raw_c  <= 1'b0;
      raw_fb <= 1'b0;
    end else begin
      cnt_a  <= div_next(cnt_a, HALF_A);
      cnt_b  <= div_next(cnt_b, HALF_B);
      cnt_c  <= div_next(cnt_c, HALF_C);
      cnt_fb <= div_next(cnt_fb, HALF_FB);
      raw_a  <= raw_a ^ tick_a;
      raw_b  <= raw_b ^ tick_b;
      raw_c  <= raw_c ^ tick_c;
      raw_fb <= raw_fb ^ tick_fb;
    end
  end

  // raw sources lined up with the enable bits, in arrival order
  assign raw_vec = {raw_fb, {3{raw_c}}, {4{raw_b}}, {4{raw_a}}};
  // gate state may change only while the source is low: no runts
  // a run bit taken while the source is low acts from the next edge
  // on; if the source rises on that edge the gate already holds the
  // new value, so a release starts with a whole high phase and a
  // freeze never cuts one that has begun
  assign next_run = (run & raw_vec) | (freeze_ena & ~raw_vec);

  // gated outputs; a high phase already begun always completes
  // every output, gated or not, is one clock behind its raw source,
  // so the ungated bank C output stays aligned with its gated peers
  // the coincidence output looks one edge ahead at the raw clocks
  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      run                   <= `OFSC_ENA_RESET;
      BANK_A_CLOCK_OUTS     <= 4'h0;
      BANK_B_CLOCK_OUTS     <= 4'h0;
      BANK_C_FREEZABLE_OUTS <= 3'h0;
      FEEDBACK_CLOCK_OUT    <= 1'b0;
      BANK_C_FIRST_OUT      <= 1'b0;
      COINCIDENCE_PULSE_OUT <= 1'b1;
    end else begin
      run <= next_run;
      BANK_A_CLOCK_OUTS     <= raw_vec[3:0] & run[3:0];
      BANK_B_CLOCK_OUTS     <= raw_vec[7:4] & run[7:4];
      BANK_C_FREEZABLE_OUTS <= raw_vec[10:8] & run[10:8];
      FEEDBACK_CLOCK_OUT    <= raw_fb & run[`OFSC_FB_BIT];
      BANK_C_FIRST_OUT      <= raw_c;
      // low when bank A and bank C are about to rise together
      COINCIDENCE_PULSE_OUT <= ~(tick_a & ~raw_a & tick_c & ~raw_c);
    end
  end

endmodule

// [verif/ofsc_chk_assertions.sv]
// port assertions for the freeze control block
`timescale 1ns/1ns
module ofsc_chk (
  // clock, reset and serial port
  input wire       CLK,
  input wire       ARST_N,
  input wire       FRZ_CLK,
  input wire       FRZ_DATA,
  // clock outputs
  input wire [3:0] BANK_A_CLOCK_OUTS,
  input wire [3:0] BANK_B_CLOCK_OUTS,
  input wire       BANK_C_FIRST_OUT,
  input wire [2:0] BANK_C_FREEZABLE_OUTS,
  input wire       FEEDBACK_CLOCK_OUT,
  input wire       COINCIDENCE_PULSE_OUT
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!ARST_N);
  // figures assume the default divider half periods
  property p_c0; !BANK_C_FIRST_OUT |-> ##[1:3] BANK_C_FIRST_OUT; endproperty
  a_c0: assert property (p_c0) else $error("c0 stalled");
  property p_sy; !COINCIDENCE_PULSE_OUT |=> COINCIDENCE_PULSE_OUT; endproperty
  a_sy: assert property (p_sy) else $error("sync pulse long");
  property p_ah; $rose(BANK_A_CLOCK_OUTS[0]) |=> BANK_A_CLOCK_OUTS[0];
  endproperty
  a_ah: assert property (p_ah) else $error("a high runt");
  property p_bh; $rose(BANK_B_CLOCK_OUTS[3]) |-> BANK_B_CLOCK_OUTS[3][*3];
  endproperty
  a_bh: assert property (p_bh) else $error("b high cut");
  property p_bl; $fell(BANK_B_CLOCK_OUTS[0]) |-> !BANK_B_CLOCK_OUTS[0][*3];
  endproperty
  a_bl: assert property (p_bl) else $error("b low cut");
  property p_al; $fell(BANK_A_CLOCK_OUTS[2]) |=> !BANK_A_CLOCK_OUTS[2];
  endproperty
  a_al: assert property (p_al) else $error("a low cut");
  property p_fb; $rose(FEEDBACK_CLOCK_OUT) |-> !BANK_A_CLOCK_OUTS[0] ||
    $rose(BANK_A_CLOCK_OUTS[0]); endproperty
  a_fb: assert property (p_fb) else $error("fb out of phase");
  property p_cf; BANK_C_FREEZABLE_OUTS[1] |-> BANK_C_FIRST_OUT; endproperty
  a_cf: assert property (p_cf) else $error("c out of phase");
endmodule
bind ofsc_freeze_ctrl ofsc_chk ofsc_chk_inst (.*);

// [verif/ofsc_frz_host.sv]
// system controller model for the serial freeze port
`timescale 1ns/1ns
module ofsc_frz_host (
  // serial port
  output reg        FRZ_CLK,
  output reg        FRZ_DATA,
  // bench side
  input  wire       go,
  input  wire [11:0] pat,
  output reg        busy
);
  integer i;
  // free-running serial clock, idle data high
  initial begin
    FRZ_CLK = 1'b0;
    FRZ_DATA = 1'b1;
    busy = 1'b0;
    forever begin
      #62 FRZ_CLK = 1'b1;
      #63 FRZ_CLK = 1'b0;
    end
  end
  // data moves on falling edges so it is steady at each rise
  always @(posedge go) begin
    busy = 1'b1;
    @(negedge FRZ_CLK) FRZ_DATA = 1'b0;
    for (i = 0; i < 12; i = i + 1) begin
      @(negedge FRZ_CLK) FRZ_DATA = pat[i];
    end
    @(negedge FRZ_CLK) FRZ_DATA = 1'b1;
    busy = 1'b0;
  end
endmodule

// [verif/output_freeze_serial_control_tb.sv]
// bench for the output freeze serial control block
`timescale 1ns/1ns
module output_freeze_serial_control_tb;
  reg         CLK, ARST_N, go;
  reg  [11:0] pat, seen;
  wire        fck, fdt, busy, c0, fb, sy;
  reg  [1:0]  c0_seen;
  reg         sy_low;
  wire [3:0]  qa, qb;
  wire [2:0]  qc;
  integer     miscompares, cmp_count, cyc, i;
  reg  [11:0] tbl [0:4];
  // bench clock
  initial begin
    CLK = 1'b0;
    forever #4 CLK = ~CLK;
  end
  ofsc_frz_host ofsc_frz_host_inst (.FRZ_CLK(fck), .FRZ_DATA(fdt), .go(go),
    .pat(pat), .busy(busy));
  ofsc_freeze_ctrl ofsc_freeze_ctrl_inst (.CLK(CLK), .ARST_N(ARST_N),
    .FRZ_CLK(fck), .FRZ_DATA(fdt), .BANK_A_CLOCK_OUTS(qa),
    .BANK_B_CLOCK_OUTS(qb), .BANK_C_FIRST_OUT(c0),
    .BANK_C_FREEZABLE_OUTS(qc), .FEEDBACK_CLOCK_OUT(fb),
    .COINCIDENCE_PULSE_OUT(sy));
  task results;
    begin
      $display("compares %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  // sends one load and lets the gating settle
  task load(input [11:0] p);
    begin
      @(negedge CLK) pat = p;
      go = 1'b1;
      @(negedge CLK) go = 1'b0;
      while (busy === 1'b1) @(negedge CLK);
      repeat (16) @(negedge CLK);
    end
  endtask
  // 12 cycles cover a full period of every bank
  // default phases never line up bank A and C rises: sync stays high
  task expect_outs(input [11:0] want);
    begin
      seen = 12'h000;
      c0_seen = 2'h0;
      sy_low = 1'b0;
      repeat (12) begin
        @(negedge CLK);
        seen = seen | {fb, qc, qb, qa};
        c0_seen = c0_seen | {c0, ~c0};
        sy_low = sy_low | ~sy;
      end
      cmp_count = cmp_count + 2;
      if (seen !== want) begin
        miscompares = miscompares + 1;
        $display("CHECK FAILED %0t seen %h want %h", $time, seen, want);
      end
      if (c0_seen !== 2'h3 || sy_low !== 1'b0) begin
        miscompares = miscompares + 1;
        $display("CHECK FAILED %0t c0 stalled or sync seen", $time);
      end
    end
  endtask
  // hang guard, about five times the expected run
  always @(posedge CLK) begin
    cyc = cyc + 1;
    if (cyc == 8000) begin
      miscompares = miscompares + 1;
      results;
    end
  end
  initial begin
    {miscompares, cmp_count, cyc} = 0;
    {go, ARST_N, pat} = 0;
    tbl[0] = 12'h000; tbl[1] = 12'hfff; tbl[2] = 12'ha5c;
    tbl[3] = 12'h801; tbl[4] = 12'h7fe;
    repeat (10) @(negedge CLK);
    ARST_N = 1'b1;
    expect_outs(12'hfff);
    for (i = 0; i < 5; i = i + 1) begin
      load(tbl[i]);
      expect_outs(tbl[i]);
      $display("test %0d done", i);
    end
    load(12'h0f0);
    load(12'h00f);
    expect_outs(12'h00f);
    $display("back to back done");
    results;
  end
endmodule
